// ===== hw/pds_edge_det.sv
`timescale 1ns/1ps
module pds_edge_det import pds_pkg::*; #(
	parameter int W = 8
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Synchronised level and edge choice
	input wire logic [W-1:0] level,
	input wire logic [W-1:0] rise_en,
	input wire logic [W-1:0] fall_en,
	input wire logic [W-1:0] enable,
	// Edge event
	output logic [W-1:0] pulse
);
	logic [W-1:0] prev_reg;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			prev_reg <= '0;
		end else begin
			prev_reg <= level;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pulse <= '0;
		end else begin
			pulse <= enable & ((rise_en & level & ~prev_reg) | (fall_en & ~level & prev_reg));
		end
	end

	edge_pulse_a: assert property (@(posedge clk) disable iff (rst)
		(enable[0] && rise_en[0] && level[0] && !prev_reg[0]) |=> pulse[0])
		else $error("selected rising edge gave no event");
endmodule : pds_edge_det

// ===== hw/pds_pkg.sv
package pds_pkg;
	// ----------------------------------------
	// Port map: index 0..8 = ports 1,2,3,4,10,11,12,14,15
	// ----------------------------------------
	localparam int NPORT = 9;
	localparam int SYNC_STAGES = 2;
	localparam int PORT3_IDX = 2;
	localparam int PORT12_IDX = 6;
	localparam int PORT10_IDX = 4;
	localparam int PORT11_IDX = 5;
	localparam int PORT14_IDX = 7;
	localparam int PORT15_IDX = 8;
	localparam logic [NPORT-1:0][15:0] LATCH_ADDR = {16'hff0f, 16'hff0e, 16'hff0c,
		16'hff0b, 16'hff0a, 16'hff04, 16'hff03, 16'hff02, 16'hff01};
	localparam logic [NPORT-1:0][15:0] DIR_ADDR = {16'hff2f, 16'hff2e, 16'hff2c,
		16'hff2b, 16'hff2a, 16'hff24, 16'hff23, 16'hff22, 16'hff21};
	localparam logic [15:0] SEG_ADDR = 16'hffb6;
	localparam logic [15:0] PULLUP3_ADDR = 16'hff33;
	localparam logic [15:0] ALT3_ADDR = 16'hff43;
	localparam logic [15:0] RISE3_ADDR = 16'hff48;
	localparam logic [15:0] FALL3_ADDR = 16'hff49;
	// ----------------------------------------
	// Implemented bits
	// ----------------------------------------
	localparam logic [NPORT-1:0][7:0] DIR_IMPL = {8'h0f, 8'h0f, 8'h01, 8'h0c, 8'h03,
		8'h01, 8'h1e, 8'h3f, 8'h0c};
	localparam logic [NPORT-1:0][7:0] LATCH_WR = {8'hff, 8'hff, 8'h01, 8'h0c, 8'h03,
		8'h01, 8'h1e, 8'h3f, 8'h0c};
	localparam logic [7:0] P12_RO_MASK = 8'h1e;
	localparam logic [7:0] SEG_IMPL_SMALL = 8'h6c;
	localparam int SEG_BIT_PORT10 = 2;
	localparam int SEG_BIT_PORT11 = 3;
	localparam int SEG_BIT_PORT14 = 5;
	localparam int SEG_BIT_PORT15 = 6;
	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [7:0] DIR_RST = 8'hff;
	localparam logic [7:0] LATCH_RST = 8'h00;
	localparam logic [7:0] SEG_RST = 8'h00;
	localparam logic [7:0] CTL_RST = 8'h00;

	// Byte or single-bit update, then only writable bits may change
	function automatic logic [7:0] pds_merge(input logic [7:0] old, input logic byte_wr,
		input logic bit_wr, input logic [7:0] wdata, input logic [2:0] idx,
		input logic val, input logic [7:0] mask);
		logic [7:0] nv;
		nv = old;
		if (byte_wr) begin
			nv = wdata;
		end else if (bit_wr) begin
			nv[idx] = val;
		end
		return (nv & mask) | (old & ~mask);
	endfunction : pds_merge

	// Input-mode bits show the pin, output-mode bits the latch
	function automatic logic [7:0] pds_read(input logic [7:0] dir, input logic [7:0] pin,
		input logic [7:0] latch, input logic [7:0] impl);
		return ((dir & pin) | (~dir & latch)) & impl;
	endfunction : pds_read
endpackage : pds_pkg

// ===== hw/pds_port_top.sv
`timescale 1ns/1ps
module pds_port_top import pds_pkg::*; #(
	parameter logic [7:0] SEG_IMPL = SEG_IMPL_SMALL
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Core register access
	input wire logic [15:0] addr,
	input wire logic wr_en,
	input wire logic bit_wr,
	input wire logic [2:0] bit_idx,
	input wire logic bit_val,
	input wire logic [7:0] wdata,
	input wire logic rd_en,
	output logic [7:0] rdata_reg,
	// Pins
	input wire logic [NPORT-1:0][7:0] pin_in,
	output logic [NPORT-1:0][7:0] pin_out_reg,
	output logic [NPORT-1:0][7:0] pin_oe_reg,
	output logic [7:0] pullup3_en_reg,
	// Neighbouring blocks
	input wire logic [7:0] osc_mode,
	input wire logic [7:0] alt3_out,
	output logic [7:0] ext_irq_input,
	output logic [7:0] segment_group_select_reg,
	output logic [7:0] key_scan_bit_reg
);
	// ----------------------------------------
	// State
	// ----------------------------------------
	logic [NPORT-1:0][7:0] dir_reg;
	logic [NPORT-1:0][7:0] latch_reg;
	logic [NPORT-1:0][7:0] pin_sync;
	logic [NPORT-1:0][7:0] rd_port;
	logic [7:0] seg_reg;
	logic [7:0] pullup3_reg;
	logic [7:0] alt3_reg;
	logic [7:0] rise3_reg;
	logic [7:0] fall3_reg;
	logic [7:0] rdata_next;
	logic [7:0] irq_pulse;

	// ----------------------------------------
	// Pin input synchronisers
	// ----------------------------------------
	pds_sync #(
		.W(NPORT * 8)
	) u_sync (
		.clk(clk),
		.rst(rst),
		.d(pin_in),
		.q(pin_sync)
	);

	function automatic logic seg_owns(input int p, input logic [7:0] seg);
		case (p)
			PORT10_IDX: return seg[SEG_BIT_PORT10];
			PORT11_IDX: return seg[SEG_BIT_PORT11];
			PORT14_IDX: return seg[SEG_BIT_PORT14];
			PORT15_IDX: return seg[SEG_BIT_PORT15];
			default: return 1'b0;
		endcase
	endfunction : seg_owns

	// ----------------------------------------
	// Per-port direction, latch and pin drive
	// ----------------------------------------
	for (genvar p = 0; p < NPORT; p++) begin : g_port
		logic dir_hit;
		logic lat_hit;
		logic [7:0] in_view;
		assign dir_hit = (addr == DIR_ADDR[p]);
		assign lat_hit = (addr == LATCH_ADDR[p]);

		always_ff @(posedge clk or posedge rst) begin
			if (rst) begin
				dir_reg[p] <= DIR_RST;
			end else if (dir_hit) begin
				// Unused bits never leave one, even if software breaks the convention
				dir_reg[p] <= pds_merge(dir_reg[p], wr_en, bit_wr, wdata, bit_idx, bit_val,
					DIR_IMPL[p]);
			end
		end

		always_ff @(posedge clk or posedge rst) begin
			if (rst) begin
				latch_reg[p] <= LATCH_RST;
			end else if (lat_hit) begin
				latch_reg[p] <= pds_merge(latch_reg[p], wr_en, bit_wr, wdata, bit_idx, bit_val,
					LATCH_WR[p]);
			end
		end

		always_ff @(posedge clk or posedge rst) begin
			if (rst) begin
				pin_oe_reg[p] <= '0;
			end else if (seg_owns(p, seg_reg)) begin
				pin_oe_reg[p] <= '0;
			end else begin
				pin_oe_reg[p] <= ~dir_reg[p] & DIR_IMPL[p];
			end
		end

		always_ff @(posedge clk or posedge rst) begin
			if (rst) begin
				pin_out_reg[p] <= '0;
			end else if (p == PORT3_IDX) begin
				pin_out_reg[p] <= ((alt3_reg & alt3_out) | (~alt3_reg & latch_reg[p]))
					& DIR_IMPL[p];
			end else begin
				pin_out_reg[p] <= latch_reg[p] & DIR_IMPL[p];
			end
		end

		if (p == PORT12_IDX) begin : g_osc
			// Oscillator pins have no latch; they only ever show the pin, masked in clock mode
			assign in_view = (pin_sync[p] & ~(osc_mode & P12_RO_MASK));
			assign rd_port[p] = pds_read(dir_reg[p], in_view, latch_reg[p], DIR_IMPL[p])
				| (in_view & P12_RO_MASK);
		end else begin : g_plain
			assign in_view = pin_sync[p];
			assign rd_port[p] = pds_read(dir_reg[p], in_view, latch_reg[p], DIR_IMPL[p])
				| (latch_reg[p] & LATCH_WR[p] & ~DIR_IMPL[p]);
		end
	end

	// ----------------------------------------
	// Segment select and port 3 control
	// ----------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			seg_reg <= SEG_RST;
		end else if (addr == SEG_ADDR) begin
			seg_reg <= pds_merge(seg_reg, wr_en, bit_wr, wdata, bit_idx, bit_val,
				SEG_IMPL);
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pullup3_reg <= CTL_RST;
		end else if (addr == PULLUP3_ADDR) begin
			pullup3_reg <= pds_merge(pullup3_reg, wr_en, bit_wr, wdata, bit_idx, bit_val,
				DIR_IMPL[PORT3_IDX]);
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			alt3_reg <= CTL_RST;
		end else if (addr == ALT3_ADDR) begin
			alt3_reg <= pds_merge(alt3_reg, wr_en, bit_wr, wdata, bit_idx, bit_val,
				DIR_IMPL[PORT3_IDX]);
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rise3_reg <= CTL_RST;
			fall3_reg <= CTL_RST;
		end else if (addr == RISE3_ADDR) begin
			rise3_reg <= pds_merge(rise3_reg, wr_en, bit_wr, wdata, bit_idx, bit_val,
				DIR_IMPL[PORT3_IDX]);
		end else if (addr == FALL3_ADDR) begin
			fall3_reg <= pds_merge(fall3_reg, wr_en, bit_wr, wdata, bit_idx, bit_val,
				DIR_IMPL[PORT3_IDX]);
		end
	end

	// Pull-up only acts while the pin is an input, so it never fights the driver
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pullup3_en_reg <= '0;
		end else begin
			pullup3_en_reg <= pullup3_reg & dir_reg[PORT3_IDX];
		end
	end

	pds_edge_det #(
		.W(8)
	) u_edge (
		.clk(clk),
		.rst(rst),
		.level(pin_sync[PORT3_IDX]),
		.rise_en(rise3_reg),
		.fall_en(fall3_reg),
		.enable(alt3_reg),
		.pulse(irq_pulse)
	);

	assign ext_irq_input = irq_pulse;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			segment_group_select_reg <= SEG_RST;
		end else begin
			segment_group_select_reg <= seg_reg;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			key_scan_bit_reg <= '0;
		end else begin
			key_scan_bit_reg <= {latch_reg[PORT15_IDX][7:4], latch_reg[PORT14_IDX][7:4]};
		end
	end

	// ----------------------------------------
	// Read path
	// ----------------------------------------
	always_comb begin
		rdata_next = 8'h00;
		for (int p = 0; p < NPORT; p++) begin
			if (addr == DIR_ADDR[p]) begin
				rdata_next = dir_reg[p];
			end
			if (addr == LATCH_ADDR[p]) begin
				rdata_next = rd_port[p];
			end
		end
		if (addr == SEG_ADDR) begin
			rdata_next = seg_reg;
		end
		if (addr == PULLUP3_ADDR) begin
			rdata_next = pullup3_reg;
		end
		if (addr == ALT3_ADDR) begin
			rdata_next = alt3_reg;
		end
		if (addr == RISE3_ADDR) begin
			rdata_next = rise3_reg;
		end
		if (addr == FALL3_ADDR) begin
			rdata_next = fall3_reg;
		end
	end

	// Data holds until the next read so a slow core may sample late
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rdata_reg <= 8'h00;
		end else if (rd_en) begin
			rdata_reg <= rdata_next;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	sequence dir3_byte_wr;
		wr_en && addr == DIR_ADDR[PORT3_IDX];
	endsequence

	sequence port2_bit_wr;
		bit_wr && !wr_en && addr == LATCH_ADDR[1];
	endsequence

	sequence port2_read;
		rd_en && addr == LATCH_ADDR[1];
	endsequence

	// Unused direction bits must survive a byte write of any value
	dir_write_a: assert property (
		dir3_byte_wr |=>
		dir_reg[PORT3_IDX] == (($past(wdata) & DIR_IMPL[PORT3_IDX]) | ~DIR_IMPL[PORT3_IDX]))
		else $error("direction byte write landed wrong");

	// A bit write must leave every other latch bit alone
	bit_write_a: assert property (
		port2_bit_wr |=>
		((latch_reg[1] ^ $past(latch_reg[1])) & ~(8'h01 << $past(bit_idx))) == 8'h00)
		else $error("bit write disturbed a neighbour bit");

	// Driver enable trails the direction register by one clock
	oe_follow_a: assert property (
		1'b1 |=>
		pin_oe_reg[PORT3_IDX] == (~$past(dir_reg[PORT3_IDX]) & DIR_IMPL[PORT3_IDX]))
		else $error("port 3 driver enable does not follow direction");

	// A group handed to segments must never be driven as a port
	seg_oe_a: assert property (
		seg_reg[SEG_BIT_PORT14] |=>
		pin_oe_reg[PORT14_IDX] == 8'h00)
		else $error("segment group still driven as port");

	seg_impl_a: assert property (
		(seg_reg & ~SEG_IMPL) == 8'h00)
		else $error("segment register holds an unimplemented bit");

	seg_out_a: assert property (
		1'b1 |=>
		segment_group_select_reg == $past(seg_reg))
		else $error("segment select output lags");

	// Port 2 has no bits 6 and 7, so they must read as zero
	unused_read_a: assert property (
		port2_read |=>
		(rdata_reg & 8'hc0) == 8'h00)
		else $error("unused data bits read back non-zero");

	osc_read_a: assert property (
		osc_mode[1] |->
		!rd_port[PORT12_IDX][1])
		else $error("oscillator pin read not zero");

	// Pull-up and driver on the same pin would waste current
	pullup_oe_a: assert property (
		(pullup3_en_reg & pin_oe_reg[PORT3_IDX]) == 8'h00)
		else $error("pull-up enabled on a driven pin");
endmodule : pds_port_top

// ===== hw/pds_sync.sv
`timescale 1ns/1ps
module pds_sync import pds_pkg::*; #(
	parameter int W = 8
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Data
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_reg;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta_reg <= '0;
			q <= '0;
		end else begin
			meta_reg <= d;
			q <= meta_reg;
		end
	end
endmodule : pds_sync

// ===== tb/pds_port_top_tb.sv
`timescale 1ns/1ps
module pds_port_top_tb import pds_pkg::*;;
	logic clk;
	logic rst;
	logic [15:0] addr;
	logic wr_en;
	logic bit_wr;
	logic [2:0] bit_idx;
	logic bit_val;
	logic [7:0] wdata;
	logic rd_en;
	logic [7:0] rdata_reg;
	logic [NPORT-1:0][7:0] pin_in;
	logic [NPORT-1:0][7:0] pin_out_reg;
	logic [NPORT-1:0][7:0] pin_oe_reg;
	logic [7:0] pullup3_en_reg;
	logic [7:0] osc_mode;
	logic [7:0] alt3_out;
	logic [7:0] ext_irq_input;
	logic [7:0] segment_group_select_reg;
	logic [7:0] key_scan_bit_reg;
	int error_cnt;
	int checked;
	int pulse_cnt = 0;
	int pulse_base;

	pds_port_top i_dut (
		.clk(clk),
		.rst(rst),
		.addr(addr),
		.wr_en(wr_en),
		.bit_wr(bit_wr),
		.bit_idx(bit_idx),
		.bit_val(bit_val),
		.wdata(wdata),
		.rd_en(rd_en),
		.rdata_reg(rdata_reg),
		.pin_in(pin_in),
		.pin_out_reg(pin_out_reg),
		.pin_oe_reg(pin_oe_reg),
		.pullup3_en_reg(pullup3_en_reg),
		.osc_mode(osc_mode),
		.alt3_out(alt3_out),
		.ext_irq_input(ext_irq_input),
		.segment_group_select_reg(segment_group_select_reg),
		.key_scan_bit_reg(key_scan_bit_reg)
	);

	// ----------------------------------------
	// Clock and edge-event counter
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	always @(posedge clk) begin
		if (ext_irq_input[4] === 1'b1) begin
			pulse_cnt <= pulse_cnt + 1;
		end
	end

	// ----------------------------------------
	// Access tasks
	// ----------------------------------------
	task automatic chk8(input string name, input logic [7:0] exp, input logic [7:0] got);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask : chk8

	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		bit_wr <= 1'b0;
		wr_en <= 1'b1;
		@(posedge clk);
		wr_en <= 1'b0;
	endtask : wr

	task automatic wbit(input logic [15:0] a, input logic [2:0] i, input logic v);
		@(posedge clk);
		addr <= a;
		bit_idx <= i;
		bit_val <= v;
		bit_wr <= 1'b1;
		wr_en <= 1'b0;
		@(posedge clk);
		wr_en <= 1'b0;
		bit_wr <= 1'b0;
	endtask : wbit

	task automatic rd_chk(input string name, input logic [15:0] a, input logic [7:0] exp);
		@(posedge clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clk);
		rd_en <= 1'b0;
		@(negedge clk);
		chk8(name, exp, rdata_reg);
	endtask : rd_chk

	// Pin inputs pass a synchroniser, so give them time to settle
	task automatic settle();
		repeat (SYNC_STAGES + 3) @(posedge clk);
	endtask : settle

	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : complete_run

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		rst = 1'b1;
		addr = 16'h0000;
		wr_en = 1'b0;
		bit_wr = 1'b0;
		bit_idx = 3'h0;
		bit_val = 1'b0;
		wdata = 8'h00;
		rd_en = 1'b0;
		pin_in = '0;
		osc_mode = 8'h00;
		alt3_out = 8'h00;
		error_cnt = 0;
		checked = 0;
		pulse_base = 0;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		settle();
		// Reset state of every port
		for (int p = 0; p < NPORT; p++) begin
			rd_chk("dir reset", DIR_ADDR[p], 8'hff);
			chk8("latch reset", 8'h00, pin_out_reg[p]);
			chk8("oe reset", 8'h00, pin_oe_reg[p]);
		end
		rd_chk("seg reset", SEG_ADDR, 8'h00);
		// Output mode drives the latch onto port 3
		wr(DIR_ADDR[PORT3_IDX], 8'he1);
		rd_chk("dir3", DIR_ADDR[PORT3_IDX], 8'he1);
		chk8("oe3", 8'h1e, pin_oe_reg[PORT3_IDX]);
		wr(LATCH_ADDR[PORT3_IDX], 8'ha5);
		settle();
		chk8("out3", 8'h04, pin_out_reg[PORT3_IDX] & 8'h1e);
		rd_chk("latch3 out", LATCH_ADDR[PORT3_IDX], 8'h04);
		// Mixed direction: bits 1,3 latch, bits 2,4 pin
		@(posedge clk);
		pin_in[PORT3_IDX] <= 8'hff;
		wr(DIR_ADDR[PORT3_IDX], 8'hf5);
		settle();
		rd_chk("latch3 mix", LATCH_ADDR[PORT3_IDX], 8'h14);
		// Port 2 bit write lands in the latch only
		wbit(LATCH_ADDR[1], 3'h3, 1'b1);
		wbit(DIR_ADDR[1], 3'h3, 1'b0);
		rd_chk("latch2 bit", LATCH_ADDR[1], 8'h08);
		// Single-bit writes touch only the addressed bit
		wbit(DIR_ADDR[0], 3'h2, 1'b0);
		rd_chk("dir1 bit", DIR_ADDR[0], 8'hfb);
		chk8("oe1", 8'h04, pin_oe_reg[0]);
		wbit(LATCH_ADDR[0], 3'h2, 1'b1);
		rd_chk("latch1 bit", LATCH_ADDR[0], 8'h04);
		// Segment register: bit and byte writes, only implemented bits
		wbit(SEG_ADDR, 3'h5, 1'b1);
		rd_chk("seg bit", SEG_ADDR, 8'h20);
		wr(SEG_ADDR, 8'hff);
		rd_chk("seg byte", SEG_ADDR, 8'h6c);
		chk8("seg out", 8'h6c, segment_group_select_reg);
		wbit(SEG_ADDR, 3'h2, 1'b0);
		// Output copy trails the register by one clock
		repeat (2) @(negedge clk);
		chk8("seg clr", 8'h68, segment_group_select_reg);
		// Port 12: read-only bits and oscillator input mode
		@(posedge clk);
		pin_in[PORT12_IDX] <= 8'h1e;
		wr(DIR_ADDR[PORT12_IDX], 8'hfe);
		wr(LATCH_ADDR[PORT12_IDX], 8'hff);
		settle();
		chk8("out12 ro", 8'h00, pin_out_reg[PORT12_IDX] & 8'h1e);
		rd_chk("latch12", LATCH_ADDR[PORT12_IDX], 8'h1f);
		@(posedge clk);
		osc_mode <= 8'h1e;
		settle();
		rd_chk("latch12 osc", LATCH_ADDR[PORT12_IDX], 8'h01);
		// Port 3 pull-ups act on input pins only (direction is f5 here)
		wr(PULLUP3_ADDR, 8'h1e);
		repeat (2) @(negedge clk);
		chk8("pullup3", 8'h14, pullup3_en_reg);
		wbit(PULLUP3_ADDR, 3'h2, 1'b0);
		repeat (2) @(negedge clk);
		chk8("pullup3 bit", 8'h10, pullup3_en_reg);
		@(posedge clk);
		alt3_out <= 8'h02;
		wr(ALT3_ADDR, 8'h12);
		settle();
		chk8("alt3 out", 8'h02, pin_out_reg[PORT3_IDX] & 8'h0a);
		// Edge choice on the interrupt input: rise only, then both
		wr(DIR_ADDR[PORT3_IDX], 8'hff);
		wr(RISE3_ADDR, 8'h10);
		wr(FALL3_ADDR, 8'h00);
		@(posedge clk);
		pin_in[PORT3_IDX] <= 8'h00;
		settle();
		pulse_base = pulse_cnt;
		@(posedge clk);
		pin_in[PORT3_IDX] <= 8'h10;
		settle();
		pin_in[PORT3_IDX] <= 8'h00;
		settle();
		chk8("rise pulses", 8'd1, 8'(pulse_cnt - pulse_base));
		wr(FALL3_ADDR, 8'h10);
		pulse_base = pulse_cnt;
		@(posedge clk);
		pin_in[PORT3_IDX] <= 8'h10;
		settle();
		pin_in[PORT3_IDX] <= 8'h00;
		settle();
		chk8("both pulses", 8'd2, 8'(pulse_cnt - pulse_base));
		// Reset in mid-run restores defaults
		@(posedge clk);
		rst <= 1'b1;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		settle();
		rd_chk("dir3 rerst", DIR_ADDR[PORT3_IDX], 8'hff);
		rd_chk("seg rerst", SEG_ADDR, 8'h00);
		complete_run();
	end
endmodule : pds_port_top_tb
